// ===== cpl_pkg.sv
package cpl_pkg;
	// register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_STATE = 8'h0C;
	localparam int CTRL_AUTOSW_BIT = 0;
	localparam int CTRL_LDET_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam int EV_ATTACH_BIT = 0;
	localparam int EV_RELEASE_BIT = 1;
	localparam int EV_AUTOSW_BIT = 2;
	localparam int EV_THERM_BIT = 3;
	localparam int NUM_EV = 4;
	localparam int STATE_LP_BIT = 4;
	localparam int STATE_MODE_POS = 8;
	// mode codes {mode_ctrl_a, mode_ctrl_b, mode_ctrl_c, limit_select}
	localparam logic [3:0] MODE_PW = 4'h3;
	localparam logic [3:0] MODE_DCP_LD = 4'h7;
	localparam logic [3:0] MODE_SDP_NO_DISCHARGE_MODE = 4'hE;
	localparam logic [3:0] MODE_CDP = 4'hF;
	localparam logic [2:0] MODE_HOLD_TOP = 3'h0;
	// time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int NS_PER_MS = 1000000;
	localparam int T_ASSERT_MS = 200;
	localparam int T_RELEASE_MS = 3000;
	localparam int T_PW_IDLE_MS = 15000;
	localparam int T_PW_DISCH_MS = 2000;
	localparam int T_AS_QUAL_MS = 1000;
	localparam int T_MODE_DISCH_MS = 500;
	localparam int CNT_W = 16;
	// intervals in ticks; "more than" intervals get one extra tick
	// divide first: ms times ns overflows a 32-bit int; tick is a whole number of ms
	localparam logic [15:0] ASSERT_TICKS = 16'(T_ASSERT_MS / (TICK_NS / NS_PER_MS));
	localparam logic [15:0] RELEASE_TICKS = 16'(T_RELEASE_MS / (TICK_NS / NS_PER_MS));
	localparam logic [15:0] PW_IDLE_TICKS = 16'(T_PW_IDLE_MS / (TICK_NS / NS_PER_MS) + 1);
	localparam logic [15:0] PW_DISCH_TICKS = 16'(T_PW_DISCH_MS / (TICK_NS / NS_PER_MS) + 1);
	localparam logic [15:0] AS_QUAL_TICKS = 16'(T_AS_QUAL_MS / (TICK_NS / NS_PER_MS));
	localparam logic [15:0] MODE_DISCH_TICKS = 16'(T_MODE_DISCH_MS / (TICK_NS / NS_PER_MS));

	typedef enum logic [3:0] {
		ST_OFF = 4'h0,
		ST_HOLD = 4'h1,
		ST_NORMAL = 4'h2,
		ST_PW_LOW = 4'h3,
		ST_PW_DISCH = 4'h4,
		ST_AS_DISCH = 4'h5,
		ST_AS_SDP = 4'h6,
		ST_MODE_DISCH = 4'h7,
		ST_THERM = 4'h8
	} cpl_state_t;
endpackage : cpl_pkg

// ===== cpl_tick.sv
`timescale 1ns/1ps
module cpl_tick #(
	parameter int CYCLES = cpl_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// slow time base pulse
	output logic tick
);
	logic [31:0] div_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= 32'h0;
			tick <= 1'b0;
		end else if (div_r == 32'(CYCLES - 1)) begin
			div_r <= 32'h0;
			tick <= 1'b1;
		end else begin
			div_r <= div_r + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule : cpl_tick

// ===== cpl_qual.sv
`timescale 1ns/1ps
module cpl_qual (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// condition and time base
	input wire logic cond,
	input wire logic tick,
	input wire logic [15:0] limit,
	// qualified condition
	output logic done
);
	logic [15:0] cnt_r;

	// any drop of the condition restarts the interval
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 16'h0;
		end else if (!cond) begin
			cnt_r <= 16'h0;
		end else if (tick && cnt_r < limit) begin
			cnt_r <= cnt_r + 16'h1;
		end
	end

	assign done = cond && (cnt_r >= limit);
endmodule : cpl_qual

// ===== cpl_top.sv
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module cpl_top #(
	parameter int TICK_CYCLES = cpl_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// mode pins
	input wire logic mode_ctrl_a,
	input wire logic mode_ctrl_b,
	input wire logic mode_ctrl_c,
	input wire logic limit_select,
	input wire logic dev_enable,
	// analog comparators
	input wire logic cur_below_pw,
	input wire logic pw_limit_hit,
	input wire logic cur_above_lo_plus,
	input wire logic cur_below_lo_minus,
	input wire logic out_short,
	input wire logic over_temp,
	input wire logic temp_cooled,
	// data line detection
	input wire logic phone_dcp_seen,
	input wire logic phone_data_link,
	// switch control
	output logic switch_on_r,
	output logic discharge_r,
	output logic use_high_limit_r,
	output logic pw_limit_r,
	output logic const_current_r,
	output logic sdp_present_r,
	output logic load_present_n_r,
	output logic irq_r
);
	cpl_pkg::cpl_state_t state_r, state_nxt;
	logic [3:0] mode_now, mode_r;
	logic tick, pw_idle_q, ld_on_q, ld_off_q, as_q, disch_done;
	logic in_disch, mode_hold, ld_mode, mode_chg, quiet_chg, lp_r, lp_nxt;
	logic [15:0] disch_limit;
	logic [1:0] ctrl_r;
	logic [3:0] status_r, mask_r, ev;
	logic rd_en, wr_en, wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] rdata;

	assign mode_now = {mode_ctrl_a, mode_ctrl_b, mode_ctrl_c, limit_select};
	assign mode_hold = (mode_now[3:1] == cpl_pkg::MODE_HOLD_TOP);
	assign ld_mode = (mode_now == cpl_pkg::MODE_DCP_LD) || (mode_now == cpl_pkg::MODE_CDP);
	assign mode_chg = (mode_now != mode_r);
	// the 1110/1111 pair is the only quiet change; all others discharge
	assign quiet_chg = ((mode_r == cpl_pkg::MODE_SDP_NO_DISCHARGE_MODE) && (mode_now == cpl_pkg::MODE_CDP)) ||
		((mode_r == cpl_pkg::MODE_CDP) && (mode_now == cpl_pkg::MODE_SDP_NO_DISCHARGE_MODE));
	assign in_disch = (state_r == cpl_pkg::ST_PW_DISCH) || (state_r == cpl_pkg::ST_AS_DISCH) ||
		(state_r == cpl_pkg::ST_MODE_DISCH);

	always_comb begin
		case (state_r)
			cpl_pkg::ST_PW_DISCH: disch_limit = cpl_pkg::PW_DISCH_TICKS;
			cpl_pkg::ST_AS_DISCH: disch_limit = cpl_pkg::MODE_DISCH_TICKS;
			default: disch_limit = cpl_pkg::MODE_DISCH_TICKS;
		endcase
	end

	cpl_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick)
	);

	cpl_qual u_pw_idle (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(cur_below_pw && state_r == cpl_pkg::ST_NORMAL),
		.tick(tick),
		.limit(cpl_pkg::PW_IDLE_TICKS),
		.done(pw_idle_q)
	);

	cpl_qual u_ld_on (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(cur_above_lo_plus && switch_on_r),
		.tick(tick),
		.limit(cpl_pkg::ASSERT_TICKS),
		.done(ld_on_q)
	);

	cpl_qual u_ld_off (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(cur_below_lo_minus && switch_on_r),
		.tick(tick),
		.limit(cpl_pkg::RELEASE_TICKS),
		.done(ld_off_q)
	);

	// a phone that took the port for a dedicated charger and never linked
	cpl_qual u_autosw (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(phone_dcp_seen && !phone_data_link && mode_now == cpl_pkg::MODE_CDP),
		.tick(tick),
		.limit(cpl_pkg::AS_QUAL_TICKS),
		.done(as_q)
	);

	cpl_qual u_disch (
		.hclk(hclk),
		.hresetn(hresetn),
		.cond(in_disch),
		.tick(tick),
		.limit(disch_limit),
		.done(disch_done)
	);

	always_comb begin
		state_nxt = state_r;
		if (!dev_enable) begin
			state_nxt = cpl_pkg::ST_OFF;
		end else if (over_temp) begin
			state_nxt = cpl_pkg::ST_THERM;
		end else begin
			case (state_r)
				cpl_pkg::ST_OFF: begin
					state_nxt = mode_hold ? cpl_pkg::ST_HOLD : cpl_pkg::ST_NORMAL;
				end
				cpl_pkg::ST_HOLD: begin
					if (!mode_hold) state_nxt = cpl_pkg::ST_NORMAL;
				end
				cpl_pkg::ST_THERM: begin
					if (temp_cooled) state_nxt = cpl_pkg::ST_NORMAL;
				end
				cpl_pkg::ST_NORMAL: begin
					if (mode_hold) begin
						state_nxt = cpl_pkg::ST_HOLD;
					end else if (mode_chg && !quiet_chg) begin
						state_nxt = cpl_pkg::ST_MODE_DISCH;
					end else if (mode_now == cpl_pkg::MODE_PW && pw_idle_q) begin
						state_nxt = cpl_pkg::ST_PW_LOW;
					end else if (ctrl_r[cpl_pkg::CTRL_AUTOSW_BIT] && as_q) begin
						state_nxt = cpl_pkg::ST_AS_DISCH;
					end
				end
				cpl_pkg::ST_PW_LOW: begin
					if (mode_chg) begin
						state_nxt = cpl_pkg::ST_MODE_DISCH;
					end else if (pw_limit_hit) begin
						state_nxt = cpl_pkg::ST_PW_DISCH;
					end
				end
				cpl_pkg::ST_PW_DISCH, cpl_pkg::ST_MODE_DISCH: begin
					if (disch_done) state_nxt = cpl_pkg::ST_NORMAL;
				end
				cpl_pkg::ST_AS_DISCH: begin
					if (disch_done) state_nxt = cpl_pkg::ST_AS_SDP;
				end
				cpl_pkg::ST_AS_SDP: begin
					if (mode_chg && !quiet_chg) begin
						state_nxt = cpl_pkg::ST_MODE_DISCH;
					end else if (phone_data_link) begin
						state_nxt = cpl_pkg::ST_NORMAL;
					end
				end
				default: state_nxt = cpl_pkg::ST_OFF;
			endcase
		end
	end

	// load-present, asserted high internally
	always_comb begin
		lp_nxt = 1'b0;
		if (mode_now == cpl_pkg::MODE_PW) begin
			lp_nxt = (state_nxt == cpl_pkg::ST_NORMAL) || (state_nxt == cpl_pkg::ST_PW_DISCH);
		end else if (ld_mode && ctrl_r[cpl_pkg::CTRL_LDET_BIT] &&
			(state_nxt == cpl_pkg::ST_NORMAL || state_nxt == cpl_pkg::ST_AS_SDP)) begin
			if (ld_on_q) begin
				lp_nxt = 1'b1;
			end else if (ld_off_q) begin
				lp_nxt = 1'b0;
			end else begin
				lp_nxt = lp_r;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= cpl_pkg::ST_OFF;
			mode_r <= 4'h0;
			lp_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			mode_r <= mode_now;
			lp_r <= lp_nxt;
		end
	end

	// switch drive, all from the next state so they move together
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			switch_on_r <= 1'b0;
			discharge_r <= 1'b0;
			use_high_limit_r <= 1'b0;
			pw_limit_r <= 1'b0;
			const_current_r <= 1'b0;
			sdp_present_r <= 1'b0;
			load_present_n_r <= 1'b1;
		end else begin
			switch_on_r <= (state_nxt == cpl_pkg::ST_NORMAL) || (state_nxt == cpl_pkg::ST_PW_LOW) ||
				(state_nxt == cpl_pkg::ST_AS_SDP);
			discharge_r <= (state_nxt == cpl_pkg::ST_HOLD) || (state_nxt == cpl_pkg::ST_PW_DISCH) ||
				(state_nxt == cpl_pkg::ST_AS_DISCH) || (state_nxt == cpl_pkg::ST_MODE_DISCH);
			// low limit in the sdp and forced modes and in ST_PW_LOW; dcp auto codes 0x10 stay high outside ST_PW_LOW
			use_high_limit_r <= (state_nxt != cpl_pkg::ST_PW_LOW) &&
				(mode_now[0] || (!mode_now[3] && mode_now[1]));
			pw_limit_r <= (state_nxt == cpl_pkg::ST_PW_LOW);
			// a short found at turn-on skips the full-current attempt
			const_current_r <= out_short && (state_nxt == cpl_pkg::ST_NORMAL ||
				state_nxt == cpl_pkg::ST_PW_LOW || state_nxt == cpl_pkg::ST_AS_SDP);
			sdp_present_r <= (state_nxt == cpl_pkg::ST_AS_SDP);
			load_present_n_r <= !lp_nxt;
		end
	end

	// bus slave: zero wait, read data registered in the address phase
	assign rd_en = hsel && htrans[1] && hready && !hwrite;
	assign wr_en = hsel && htrans[1] && hready && hwrite;

	always_comb begin
		case (haddr[7:0])
			cpl_pkg::OFS_CTRL: rdata = {30'h0, ctrl_r};
			cpl_pkg::OFS_STATUS: rdata = {28'h0, status_r};
			cpl_pkg::OFS_MASK: rdata = {28'h0, mask_r};
			cpl_pkg::OFS_STATE: rdata = {20'h0, mode_r, 3'h0, lp_r, state_r};
			default: rdata = 32'h0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= 32'h0;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= rd_en ? rdata : 32'h0;
			wr_pend_r <= wr_en;
			wr_addr_r <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= cpl_pkg::CTRL_RESET;
			mask_r <= cpl_pkg::MASK_RESET;
		end else if (wr_pend_r) begin
			if (wr_addr_r == cpl_pkg::OFS_CTRL) ctrl_r <= hwdata[1:0];
			if (wr_addr_r == cpl_pkg::OFS_MASK) mask_r <= hwdata[3:0];
		end
	end

	assign ev[cpl_pkg::EV_ATTACH_BIT] = lp_nxt && !lp_r;
	assign ev[cpl_pkg::EV_RELEASE_BIT] = !lp_nxt && lp_r;
	assign ev[cpl_pkg::EV_AUTOSW_BIT] = (state_nxt == cpl_pkg::ST_AS_DISCH) &&
		(state_r != cpl_pkg::ST_AS_DISCH);
	assign ev[cpl_pkg::EV_THERM_BIT] = (state_nxt == cpl_pkg::ST_THERM) &&
		(state_r != cpl_pkg::ST_THERM);

	// read clears, but an event in the same cycle survives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_r <= 4'h0;
			irq_r <= 1'b0;
		end else begin
			status_r <= ((rd_en && haddr[7:0] == cpl_pkg::OFS_STATUS) ? 4'h0 : status_r) | ev;
			irq_r <= |(status_r & mask_r);
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	pw_only_a: assert property ((state_r == cpl_pkg::ST_PW_LOW) |->
		($past(mode_now) == cpl_pkg::MODE_PW)) else $error("low power state outside 0011");
	pw_hold_a: assert property ((state_r == cpl_pkg::ST_NORMAL && mode_r == cpl_pkg::MODE_PW) |->
		!load_present_n_r) else $error("load present not held while charging");
	pw_release_a: assert property ($rose(state_r == cpl_pkg::ST_PW_LOW) |->
		load_present_n_r && pw_limit_r && !use_high_limit_r) else $error("idle entry wrong");
	pw_wake_a: assert property ((state_r == cpl_pkg::ST_PW_LOW && pw_limit_hit && dev_enable &&
		!over_temp && !mode_chg) |=> (state_r == cpl_pkg::ST_PW_DISCH && !load_present_n_r))
		else $error("wake on limit missed");
	disch_len_a: assert property ($rose(state_r == cpl_pkg::ST_PW_DISCH) |->
		(discharge_r && !switch_on_r) [*8]) else $error("wake discharge too short");
	pw_exit_a: assert property ((state_r == cpl_pkg::ST_NORMAL &&
		$past(state_r) == cpl_pkg::ST_PW_DISCH) |-> use_high_limit_r && switch_on_r)
		else $error("no high limit after discharge");
	ld_assert_a: assert property ((ld_on_q && ld_mode && ctrl_r[cpl_pkg::CTRL_LDET_BIT] &&
		state_nxt == cpl_pkg::ST_NORMAL && !(mode_now == cpl_pkg::MODE_PW)) |=> !load_present_n_r)
		else $error("load present not asserted");
	sdp_no_discharge_mode_cdp_a: assert property ((state_r == cpl_pkg::ST_NORMAL && mode_r == cpl_pkg::MODE_SDP_NO_DISCHARGE_MODE &&
		mode_now == cpl_pkg::MODE_CDP && dev_enable && !over_temp) |=> !discharge_r)
		else $error("discharge on quiet change");
	therm_off_a: assert property ((over_temp && dev_enable) |=> !switch_on_r ##1
		(!switch_on_r || $past(temp_cooled))) else $error("switch on while hot");
	short_cc_a: assert property (($rose(dev_enable) && out_short && !over_temp && !mode_hold)
		|=> switch_on_r && const_current_r) else $error("no constant current on short");

	pw_cycle_c: cover property ((state_r == cpl_pkg::ST_PW_LOW) ##1 (state_r == cpl_pkg::ST_PW_DISCH));
	autosw_c: cover property ((state_r == cpl_pkg::ST_AS_SDP) ##1 (state_r == cpl_pkg::ST_NORMAL));
	ld_c: cover property ($fell(load_present_n_r) && mode_r == cpl_pkg::MODE_CDP);
	therm_c: cover property ((state_r == cpl_pkg::ST_THERM) ##1 (state_r == cpl_pkg::ST_NORMAL));
endmodule : cpl_top

// ===== cpl_ec_model.sv
`timescale 1ns/1ps
module cpl_ec_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// port plan from the system side
	input wire logic [3:0] want_mode,
	input wire logic peer_busy,
	input wire logic load_present_n,
	// mode pins
	output logic mode_ctrl_a,
	output logic mode_ctrl_b,
	output logic mode_ctrl_c,
	output logic limit_select
);
	logic [3:0] mode_r;

	// a port with its own load keeps charging; only idle ports are demoted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r <= 4'hF;
		end else if (want_mode == 4'hF && peer_busy && load_present_n) begin
			mode_r <= 4'hE;
		end else begin
			mode_r <= want_mode;
		end
	end

	assign {mode_ctrl_a, mode_ctrl_b, mode_ctrl_c, limit_select} = mode_r;
endmodule : cpl_ec_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
	// short time base keeps the long intervals inside the run budget
	localparam int TC = 2;
	localparam int SW = 0, DIS = 1, SDP = 2, LPN = 3;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic m_a, m_b, m_c, m_ls, dev_enable, peer_busy, disch_seen;
	logic cur_below_pw, pw_limit_hit, cur_above_lo_plus, cur_below_lo_minus;
	logic out_short, over_temp, temp_cooled, phone_dcp_seen, phone_data_link;
	logic switch_on_r, discharge_r, use_high_limit_r, pw_limit_r, const_current_r;
	logic sdp_present_r, load_present_n_r, irq_r;
	logic [3:0] want_mode, obs;
	int n_fail, checked, n;

	assign hready = hreadyout;
	assign obs = {load_present_n_r, sdp_present_r, discharge_r, switch_on_r};

	cpl_top #(.TICK_CYCLES(TC)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.mode_ctrl_a(m_a), .mode_ctrl_b(m_b), .mode_ctrl_c(m_c), .limit_select(m_ls),
		.dev_enable(dev_enable), .cur_below_pw(cur_below_pw), .pw_limit_hit(pw_limit_hit),
		.cur_above_lo_plus(cur_above_lo_plus), .cur_below_lo_minus(cur_below_lo_minus),
		.out_short(out_short), .over_temp(over_temp), .temp_cooled(temp_cooled),
		.phone_dcp_seen(phone_dcp_seen), .phone_data_link(phone_data_link),
		.switch_on_r(switch_on_r), .discharge_r(discharge_r),
		.use_high_limit_r(use_high_limit_r), .pw_limit_r(pw_limit_r),
		.const_current_r(const_current_r), .sdp_present_r(sdp_present_r),
		.load_present_n_r(load_present_n_r), .irq_r(irq_r));

	cpl_ec_model ec_u (.hclk(hclk), .hresetn(hresetn), .want_mode(want_mode),
		.peer_busy(peer_busy), .load_present_n(load_present_n_r), .mode_ctrl_a(m_a),
		.mode_ctrl_b(m_b), .mode_ctrl_c(m_c), .limit_select(m_ls));

	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end

	always @(posedge hclk) if (discharge_r === 1'h1) disch_seen <= 1'h1;

	task print_verdict;
		if (n_fail == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask : chk

	// two extra ticks and a few cycles of slack on every interval
	task chk_t(input int ticks);
		checked++;
		if (n < ticks * TC - 2 || n > (ticks + 2) * TC + 8) begin
			n_fail++;
			$display("unexpected at %0t: interval %0d cycles for %0d ticks", $time, n, ticks);
		end
	endtask : chk_t

	task wait_bit(input int idx, input logic v, input int maxc);
		n = 0;
		while (obs[idx] !== v) begin
			@(posedge hclk);
			n++;
			if (n > maxc) begin
				n_fail++;
				$display("unexpected at %0t: output never settled", $time);
				print_verdict;
			end
		end
	endtask : wait_bit

	task cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask : cyc

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		hsel <= 1'h1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'h1 && k < 50);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'h1 && k < 100);
		rd = hrdata;
		if (k >= 100) begin
			n_fail++;
			$display("unexpected at %0t: bus stalled", $time);
			print_verdict;
		end
	endtask : bus

	initial begin
		{hresetn, hsel, hwrite, haddr, hwdata, htrans, peer_busy, disch_seen} = '0;
		{cur_below_pw, pw_limit_hit, cur_above_lo_plus, cur_below_lo_minus} = 4'h0;
		{out_short, over_temp, temp_cooled, phone_dcp_seen, phone_data_link} = 5'h0;
		hsize = 3'h2;
		dev_enable = 1'h1;
		want_mode = 4'hF;
		n_fail = 0;
		checked = 0;
		cyc(20);
		chk(load_present_n_r, 32'h1);
		chk(switch_on_r, 32'h0);
		hresetn <= 1'h1;
		cyc(1);
		bus(1'h0, cpl_pkg::OFS_CTRL, 32'h0);
		chk(rd, {30'h0, cpl_pkg::CTRL_RESET});
		chk(hresp, 32'h0);
		bus(1'h0, cpl_pkg::OFS_MASK, 32'h0);
		chk(rd, {28'h0, cpl_pkg::MASK_RESET});
		bus(1'h1, 8'h10, 32'hFFFFFFFF);
		bus(1'h0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		wait_bit(SW, 1'h1, 3000);
		cyc(2);
		chk(use_high_limit_r, 32'h1);
		bus(1'h1, cpl_pkg::OFS_MASK, 32'h1);
		// a short dip must restart the qualification count
		cur_above_lo_plus <= 1'h1;
		cyc(100 * TC);
		cur_above_lo_plus <= 1'h0;
		cyc(4);
		cur_above_lo_plus <= 1'h1;
		wait_bit(LPN, 1'h0, 3000);
		chk_t(200);
		cyc(2);
		chk(irq_r, 32'h1);
		bus(1'h0, cpl_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'hF, 32'h1);
		cyc(2);
		chk(irq_r, 32'h0);
		cur_above_lo_plus <= 1'h0;
		cur_below_lo_minus <= 1'h1;
		wait_bit(LPN, 1'h1, 8000);
		chk_t(3000);
		cur_below_lo_minus <= 1'h0;
		bus(1'h0, cpl_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'hF, 32'h2);
		disch_seen <= 1'h0;
		peer_busy <= 1'h1;
		cyc(10);
		chk(use_high_limit_r, 32'h0);
		peer_busy <= 1'h0;
		cyc(10);
		chk(use_high_limit_r, 32'h1);
		chk(disch_seen, 32'h0);
		phone_dcp_seen <= 1'h1;
		wait_bit(DIS, 1'h1, 4000);
		chk_t(1000);
		wait_bit(SDP, 1'h1, 2000);
		chk_t(500);
		chk(switch_on_r, 32'h1);
		disch_seen <= 1'h0;
		phone_data_link <= 1'h1;
		wait_bit(SDP, 1'h0, 50);
		chk(switch_on_r, 32'h1);
		chk(disch_seen, 32'h0);
		{phone_dcp_seen, phone_data_link} <= 2'h0;
		bus(1'h0, cpl_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'hF, 32'h4);
		repeat (2) begin
			over_temp <= 1'h1;
			cyc(1);
			over_temp <= 1'h0;
			cyc(2);
			chk(switch_on_r, 32'h0);
			temp_cooled <= 1'h1;
			wait_bit(SW, 1'h1, 20);
			temp_cooled <= 1'h0;
		end
		bus(1'h0, cpl_pkg::OFS_STATUS, 32'h0);
		chk(rd & 32'hF, 32'h8);
		dev_enable <= 1'h0;
		cyc(4);
		out_short <= 1'h1;
		dev_enable <= 1'h1;
		wait_bit(SW, 1'h1, 3000);
		chk(const_current_r, 32'h1);
		out_short <= 1'h0;
		cyc(2);
		want_mode <= 4'h3;
		wait_bit(DIS, 1'h1, 20);
		wait_bit(DIS, 1'h0, 2000);
		chk_t(500);
		wait_bit(SW, 1'h1, 50);
		cyc(2);
		chk(load_present_n_r, 32'h0);
		cur_below_pw <= 1'h1;
		wait_bit(LPN, 1'h1, 40000);
		chk_t(15001);
		chk(pw_limit_r, 32'h1);
		chk(use_high_limit_r, 32'h0);
		cur_below_pw <= 1'h0;
		pw_limit_hit <= 1'h1;
		wait_bit(LPN, 1'h0, 5);
		chk(discharge_r, 32'h1);
		pw_limit_hit <= 1'h0;
		wait_bit(DIS, 1'h0, 5000);
		chk_t(2001);
		cyc(2);
		chk(switch_on_r, 32'h1);
		chk(use_high_limit_r, 32'h1);
		chk(pw_limit_r, 32'h0);
		print_verdict;
	end
endmodule : testbench
